// ===== bench/tb.sv
// Self-checking bench for the reload/capture timer, APB master in the bench.
// Assumes trct_pkg and trct_cfg.svh are compiled first; one 40 MHz clock.
`include "trct_cfg.svh"

module tb
   import trct_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // ----------------------------------------------------------------------
   // Signals and register map
   // ----------------------------------------------------------------------
   localparam logic [11:0] A_CTRL = {`TRCT_IDX_CTRL, 2'b00};
   localparam logic [11:0] A_RLO  = {`TRCT_IDX_RELOAD_LO, 2'b00};
   localparam logic [11:0] A_RHI  = {`TRCT_IDX_RELOAD_HI, 2'b00};
   localparam logic [11:0] A_CLO  = {`TRCT_IDX_COUNT_LO, 2'b00};
   localparam logic [11:0] A_CHI  = {`TRCT_IDX_COUNT_HI, 2'b00};
   localparam logic [11:0] A_CLK  = {`TRCT_IDX_CLKCTRL, 2'b00};
   localparam logic [11:0] A_ST   = {`TRCT_IDX_STATUS, 2'b00};
   localparam logic [11:0] A_EN   = {`TRCT_IDX_IRQ_EN, 2'b00};
   localparam logic [11:0] A_CLR  = {`TRCT_IDX_IRQ_CLR, 2'b00};

   logic        pclk    = 1'b0;
   logic        presetn = 1'b0;
   logic [11:0] paddr   = 12'h000;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [31:0] pwdata  = 32'h0;
   logic        pready;
   logic [31:0] prdata;
   logic        pslverr;
   logic        ext_clk = 1'b0;
   logic        sof_in  = 1'b0;
   logic        lfo_in  = 1'b0;
   logic        irq;
   int          fail_count  = 0;
   int          checks_done = 0;
   logic        last_err;

   always #12.5 pclk = ~pclk;

   trct_timer i_trct_timer (
      .pclk    (pclk),
      .presetn (presetn),
      .paddr   (paddr),
      .psel    (psel),
      .penable (penable),
      .pwrite  (pwrite),
      .pwdata  (pwdata),
      .pready  (pready),
      .prdata  (prdata),
      .pslverr (pslverr),
      .ext_clk (ext_clk),
      .sof_in  (sof_in),
      .lfo_in  (lfo_in),
      .irq     (irq)
   );

   // ----------------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------------
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : tally_and_finish

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : check

   // Request held until pready is sampled high; data taken at that edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      int n;
      n = 0;
      @(posedge pclk);
      paddr   <= a;
      pwrite  <= w;
      pwdata  <= d;
      psel    <= 1'b1;
      penable <= 1'b0;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      r        = prdata;
      last_err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) begin
         fail_count++;
         tally_and_finish();
      end
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [31:0] r;
      apb(1'b1, a, {24'h0, d}, r);
   endtask : wr

   task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
      logic [31:0] r;
      apb(1'b0, a, 32'h0, r);
      check(r, {24'h0, exp});
   endtask : rd_chk

   task automatic rd(input logic [11:0] a, output logic [7:0] v);
      logic [31:0] r;
      apb(1'b0, a, 32'h0, r);
      v = r[7:0];
   endtask : rd

   // Bounded wait for the interrupt line
   task automatic wait_irq(input int lim);
      int n;
      n = 0;
      while (irq !== 1'b1 && n < lim) begin
         @(posedge pclk);
         n++;
      end
      if (n >= lim) begin
         fail_count++;
         tally_and_finish();
      end
   endtask : wait_irq

   // ----------------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------------
   task automatic t_reset_map();
      rd_chk(A_CTRL, 8'h00);
      rd_chk(A_RLO, 8'h00);
      rd_chk(A_RHI, 8'h00);
      rd_chk(A_CHI, 8'h00);
      rd_chk(12'h004, 8'h00);
      check(last_err, 1'b1);
      wr(A_ST, 8'h07);
      rd_chk(A_ST, 8'h00);
   endtask : t_reset_map

   task automatic t_wrap16();
      logic [7:0] a;
      logic [7:0] b;
      wr(A_CLK, 8'h10);
      wr(A_EN, 8'h01);
      wr(A_RLO, 8'h34);
      wr(A_RHI, 8'h12);
      wr(A_CLO, 8'hfe);
      wr(A_CHI, 8'hff);
      wr(A_CTRL, 8'h04);
      wait_irq(40);
      repeat (20) @(posedge pclk);
      check(irq, 1'b1);
      rd_chk(A_CTRL, 8'hc4);
      rd_chk(A_CHI, 8'h12);
      rd_chk(A_CTRL, 8'hc4);
      wr(A_CLR, 8'h03);
      rd_chk(A_CTRL, 8'h04);
      check(irq, 1'b0);
      wr(A_CTRL, 8'h00);
      rd(A_CLO, a);
      repeat (10) @(posedge pclk);
      rd(A_CLO, b);
      check(b, a);
   endtask : t_wrap16

   task automatic t_low_irq();
      wr(A_EN, 8'h03);
      wr(A_CLO, 8'hf0);
      wr(A_CHI, 8'h00);
      wr(A_CTRL, 8'h04);
      repeat (40) @(posedge pclk);
      check(irq, 1'b0);
      rd_chk(A_CTRL, 8'h44);
      wr(A_CTRL, 8'h24);
      wait_irq(300);
      rd_chk(A_CTRL, 8'h64);
      wr(A_CTRL, 8'h00);
   endtask : t_low_irq

   // Split with run low: only the low byte moves and reloads
   task automatic t_split();
      logic [7:0] v;
      wr(A_CLK, 8'h10);
      wr(A_RLO, 8'h80);
      wr(A_CLO, 8'hff);
      wr(A_CHI, 8'h10);
      wr(A_CTRL, 8'h28);
      wait_irq(20);
      rd_chk(A_CHI, 8'h10);
      rd_chk(A_CTRL, 8'h68);
      rd(A_CLO, v);
      check(v >= 8'h80 && v < 8'ha0, 1'b1);
      wr(A_CTRL, 8'h00);
   endtask : t_split

   // Divided sources: 12 pclk per tick, and 8 external rising edges per tick
   task automatic t_dividers();
      logic [7:0] v;
      wr(A_CLK, 8'h00);
      wr(A_CLO, 8'h00);
      wr(A_CTRL, 8'h04);
      repeat (120) @(posedge pclk);
      wr(A_CTRL, 8'h00);
      rd(A_CLO, v);
      check(v >= 8'd9 && v <= 8'd11, 1'b1);
      wr(A_CLO, 8'h00);
      wr(A_CTRL, 8'h05);
      repeat (128) begin
         @(posedge pclk);
         ext_clk <= ~ext_clk;
         @(posedge pclk);
      end
      repeat (8) @(posedge pclk);
      wr(A_CTRL, 8'h01);
      rd(A_CLO, v);
      check(v >= 8'd7 && v <= 8'd9, 1'b1);
   endtask : t_dividers

   // Counter held still so the captured value is known exactly
   task automatic t_capture();
      wr(A_CTRL, 8'h00);
      wr(A_EN, 8'h04);
      wr(A_CLO, 8'hcd);
      wr(A_CHI, 8'hab);
      wr(A_CTRL, 8'h10);
      @(posedge pclk);
      sof_in <= 1'b1;
      repeat (4) @(posedge pclk);
      sof_in <= 1'b0;
      wait_irq(20);
      rd_chk(A_RLO, 8'hcd);
      rd_chk(A_RHI, 8'hab);
      rd_chk(A_ST, 8'h04);
      wr(A_CLR, 8'h07);
      rd_chk(A_ST, 8'h00);
      wr(A_CTRL, 8'h12);
      wr(A_CLO, 8'h22);
      wr(A_CHI, 8'h11);
      @(posedge pclk);
      lfo_in <= 1'b1;
      repeat (8) @(posedge pclk);
      check(irq, 1'b0);
      rd_chk(A_RLO, 8'hcd);
      lfo_in <= 1'b0;
      wait_irq(20);
      rd_chk(A_RLO, 8'h22);
      rd_chk(A_RHI, 8'h11);
   endtask : t_capture

   // Capture modes never reload: split low byte and 16-bit count wrap to zero
   task automatic t_cap_free();
      logic [7:0] v;
      wr(A_CLR, 8'h07);
      wr(A_CLK, 8'h10);
      wr(A_CLO, 8'hf0);
      wr(A_CHI, 8'h5a);
      wr(A_CTRL, 8'h18);
      repeat (30) @(posedge pclk);
      sof_in <= 1'b1;
      repeat (4) @(posedge pclk);
      sof_in <= 1'b0;
      wait_irq(20);
      rd_chk(A_RHI, 8'h5a);
      rd(A_RLO, v);
      check(v >= 8'h08 && v < 8'h20, 1'b1);
      rd_chk(A_CTRL, 8'h58);
      wr(A_CTRL, 8'h10);
      wr(A_CLO, 8'hfd);
      wr(A_CHI, 8'hff);
      wr(A_CTRL, 8'h14);
      wr(A_CTRL, 8'h10);
      rd_chk(A_CLO, 8'h00);
      rd_chk(A_CHI, 8'h00);
      rd_chk(A_CTRL, 8'hd0);
   endtask : t_cap_free

   // ----------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      t_reset_map();
      t_wrap16();
      t_low_irq();
      t_split();
      t_dividers();
      t_capture();
      t_cap_free();
      tally_and_finish();
   end

endmodule : tb

// ===== design/trct_tick_gen.sv
// Count-clock ticks and synchronised events for the reload/capture timer.
// Assumes ext_clk, sof_in and lfo_in may be asynchronous to pclk.
`include "trct_cfg.svh"

module trct_tick_gen
   import trct_pkg::*;
(
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic ext_clk,
   input  wire logic sof_in,
   input  wire logic lfo_in,
   output logic      div_sys_tick,
   output logic      div_ext_tick,
   output logic      sof_evt,
   output logic      lfo_fall
);

   logic [2:0] sync1_r;
   logic [2:0] sync2_r;
   logic [2:0] sync3_r;
   logic [3:0] sys_cnt_r;
   logic [2:0] ext_cnt_r;
   logic       ext_rise;

   // ----------------------------------------------------------------------
   // Synchronisers and edge detection
   // ----------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin // [RL18]
      if (!presetn) begin
         sync1_r <= 3'h0;
         sync2_r <= 3'h0;
         sync3_r <= 3'h0;
      end else begin
         sync1_r <= {lfo_in, sof_in, ext_clk};
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
      end
   end

   // Edges come from stages two and three so each occurrence fires once
   assign ext_rise = sync2_r[0] & ~sync3_r[0]; // [RL18]
   assign sof_evt  = sync2_r[1] & ~sync3_r[1]; // [RL18]
   assign lfo_fall = ~sync2_r[2] & sync3_r[2]; // [RL18]

   // ----------------------------------------------------------------------
   // Dividers
   // ----------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin // [RL13]
      if (!presetn) begin
         sys_cnt_r <= 4'h0;
      end else if (div_sys_tick) begin
         sys_cnt_r <= 4'h0;
      end else begin
         sys_cnt_r <= sys_cnt_r + 4'h1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin // [RL13]
      if (!presetn) begin
         ext_cnt_r <= 3'h0;
      end else if (ext_rise) begin
         ext_cnt_r <= ext_cnt_r + 3'h1;
      end
   end

   assign div_sys_tick = sys_cnt_r == 4'(`TRCT_DIV_SYS - 1); // [RL13]
   assign div_ext_tick = ext_rise && ext_cnt_r == 3'(`TRCT_DIV_EXT - 1); // [RL13]

   AST_DIV_SYS_GAP: assert property ( // [RL13]
      @(posedge pclk) disable iff (!presetn)
      div_sys_tick |=> !div_sys_tick [*8])
      else $error("system divider ticked early");

endmodule : trct_tick_gen

// ===== design/trct_timer.sv
// Reload/capture timer: 16-bit or split 8-bit counter with APB registers.
// Assumes an APB master on pclk; ext_clk, sof_in and lfo_in are raw inputs.
//
// Added by the designer: the APB register port.
`include "trct_cfg.svh"

// Behaviour
// [RL1] 16-bit wrap loads reload, sets high flag
// [RL2] 16-bit overflow requests interrupt when enabled
// [RL3] Low wrap also interrupts when low enable set
// [RL4] Split mode: two 8-bit auto-reload timers
// [RL5] Split: run bit gates high byte only
// [RL6] Per-byte select: system clock or selected source
// [RL7] High wrap sets high flag; low always sets low
// [RL8] Split interrupts: high, or either with low enable
// [RL9] Flags cleared only by software
// [RL10] Capture source: frame start or oscillator fall
// [RL11] 16-bit capture: free count, latch on event
// [RL12] Split capture: free bytes, latch both on event
// [RL13] External select: divide by 12 or ext/8
// [RL14] High flag with enable drives interrupt
// [RL15] Non-split: run bit counts or holds
// [RL16] High clock select only matters in split
// [RL17] Reload bytes hold reload or capture, reset zero
// [RL18] Inputs synchronised, each edge acts once
// [RL19] Hardware flag set beats software write
module trct_timer
   import trct_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   input  wire logic        ext_clk,
   input  wire logic        sof_in,
   input  wire logic        lfo_in,
   output logic             irq
);

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   trct_byte_t ctrl_r;
   trct_byte_t clkctrl_r;
   trct_byte_t reload_lo_r;
   trct_byte_t reload_hi_r;
   trct_byte_t count_lo_r;
   trct_byte_t count_hi_r;
   logic       cap_flag_r;
   trct_stat_t irq_en_r;
   trct_stat_t status;
   logic [31:0] rd_val;
   logic       rd_hit;

   logic div_sys_tick;
   logic div_ext_tick;
   logic sof_evt;
   logic lfo_fall;

   logic split_mode_en;
   logic capture_en;
   logic run_ctrl;
   logic lo_tick;
   logic hi_tick;
   logic lo_adv;
   logic hi_adv;
   logic lo_wrap;
   logic hi_wrap;
   logic cap_evt;

   logic wr_access;
   logic wr_ctrl;
   logic wr_clk;
   logic wr_rl_lo;
   logic wr_rl_hi;
   logic wr_cnt_lo;
   logic wr_cnt_hi;
   logic wr_en;
   logic wr_clr;

   trct_tick_gen u_tick (
      .pclk         (pclk),
      .presetn      (presetn),
      .ext_clk      (ext_clk),
      .sof_in       (sof_in),
      .lfo_in       (lfo_in),
      .div_sys_tick (div_sys_tick),
      .div_ext_tick (div_ext_tick),
      .sof_evt      (sof_evt),
      .lfo_fall     (lfo_fall)
   );

   // ----------------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------------
   // Zero-wait slave: a write lands on the single access edge
   assign pready    = 1'b1;
   assign wr_access = psel & penable & pwrite;
   assign wr_ctrl   = wr_access & trct_hit(paddr, `TRCT_IDX_CTRL);
   assign wr_clk    = wr_access & trct_hit(paddr, `TRCT_IDX_CLKCTRL);
   assign wr_rl_lo  = wr_access & trct_hit(paddr, `TRCT_IDX_RELOAD_LO);
   assign wr_rl_hi  = wr_access & trct_hit(paddr, `TRCT_IDX_RELOAD_HI);
   assign wr_cnt_lo = wr_access & trct_hit(paddr, `TRCT_IDX_COUNT_LO);
   assign wr_cnt_hi = wr_access & trct_hit(paddr, `TRCT_IDX_COUNT_HI);
   assign wr_en     = wr_access & trct_hit(paddr, `TRCT_IDX_IRQ_EN);
   assign wr_clr    = wr_access & trct_hit(paddr, `TRCT_IDX_IRQ_CLR);

   assign status = {cap_flag_r, ctrl_r[`TRCT_CTRL_TFL], ctrl_r[`TRCT_CTRL_TFH]};

   always_comb begin
      rd_val = 32'h0000_0000;
      rd_hit = 1'b1;
      unique case (1'b1)
         trct_hit(paddr, `TRCT_IDX_CTRL):      rd_val[7:0] = ctrl_r;
         trct_hit(paddr, `TRCT_IDX_CLKCTRL):   rd_val[7:0] = clkctrl_r;
         trct_hit(paddr, `TRCT_IDX_RELOAD_LO): rd_val[7:0] = reload_lo_r;
         trct_hit(paddr, `TRCT_IDX_RELOAD_HI): rd_val[7:0] = reload_hi_r;
         trct_hit(paddr, `TRCT_IDX_COUNT_LO):  rd_val[7:0] = count_lo_r;
         trct_hit(paddr, `TRCT_IDX_COUNT_HI):  rd_val[7:0] = count_hi_r;
         trct_hit(paddr, `TRCT_IDX_STATUS):    rd_val[2:0] = status;
         trct_hit(paddr, `TRCT_IDX_IRQ_EN):    rd_val[2:0] = irq_en_r;
         trct_hit(paddr, `TRCT_IDX_IRQ_CLR):   rd_val      = 32'h0000_0000;
         default:                              rd_hit      = 1'b0;
      endcase
   end

   // Read data is caught in the setup cycle so it is a flop in the access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= rd_val;
      end
   end

   assign pslverr = psel & penable & ~rd_hit;

   // ----------------------------------------------------------------------
   // Mode and clock selection
   // ----------------------------------------------------------------------
   assign split_mode_en = ctrl_r[`TRCT_CTRL_SPLIT];
   assign capture_en    = ctrl_r[`TRCT_CTRL_CE];
   assign run_ctrl      = ctrl_r[`TRCT_CTRL_RUN];

   assign lo_tick = trct_tick_sel(clkctrl_r[`TRCT_CLK_LSEL], ctrl_r[`TRCT_CTRL_XCLK],
                                  div_sys_tick, div_ext_tick); // [RL6] [RL13]
   // Outside split the whole timer runs from the low-byte clock
   assign hi_tick = trct_tick_sel(clkctrl_r[`TRCT_CLK_HSEL], ctrl_r[`TRCT_CTRL_XCLK],
                                  div_sys_tick, div_ext_tick); // [RL16]

   assign lo_adv  = split_mode_en ? lo_tick : (run_ctrl & lo_tick); // [RL5] [RL15]
   assign hi_adv  = split_mode_en ? (run_ctrl & hi_tick)
                                  : (run_ctrl & lo_tick & (count_lo_r == 8'hff)); // [RL5]
   assign lo_wrap = lo_adv & (count_lo_r == 8'hff); // [RL7]
   assign hi_wrap = hi_adv & (count_hi_r == 8'hff); // [RL7]

   assign cap_evt = capture_en & (ctrl_r[`TRCT_CTRL_CSS] ? lfo_fall : sof_evt); // [RL10]

   // ----------------------------------------------------------------------
   // Counter bytes
   // ----------------------------------------------------------------------
   // A software write to a count byte wins over counting in that cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_lo_r <= `TRCT_RST_BYTE;
      end else if (wr_cnt_lo) begin
         count_lo_r <= pwdata[7:0];
      end else if (lo_wrap && !capture_en && (split_mode_en || hi_wrap)) begin
         count_lo_r <= reload_lo_r; // [RL1] [RL4]
      end else if (lo_adv) begin
         count_lo_r <= count_lo_r + 8'h01; // [RL11] [RL12]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_hi_r <= `TRCT_RST_BYTE;
      end else if (wr_cnt_hi) begin
         count_hi_r <= pwdata[7:0];
      end else if (hi_wrap && !capture_en) begin
         count_hi_r <= reload_hi_r; // [RL1] [RL4]
      end else if (hi_adv) begin
         count_hi_r <= count_hi_r + 8'h01; // [RL11] [RL12]
      end
   end

   // ----------------------------------------------------------------------
   // Reload / capture bytes
   // ----------------------------------------------------------------------
   // Capture beats a software write so a measured period is never lost
   always_ff @(posedge pclk or negedge presetn) begin // [RL17]
      if (!presetn) begin
         reload_lo_r <= `TRCT_RST_BYTE;
         reload_hi_r <= `TRCT_RST_BYTE;
      end else if (cap_evt) begin
         reload_lo_r <= count_lo_r; // [RL11] [RL12]
         reload_hi_r <= count_hi_r; // [RL11] [RL12]
      end else begin
         if (wr_rl_lo) begin
            reload_lo_r <= pwdata[7:0];
         end
         if (wr_rl_hi) begin
            reload_hi_r <= pwdata[7:0];
         end
      end
   end

   // ----------------------------------------------------------------------
   // Control, flags and interrupt
   // ----------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= `TRCT_RST_BYTE;
      end else begin
         if (wr_ctrl) begin
            ctrl_r[5:0] <= pwdata[5:0];
         end
         // Flags: hardware set first, then software write or clear
         if (hi_wrap) begin
            ctrl_r[`TRCT_CTRL_TFH] <= 1'b1; // [RL7] [RL19]
         end else if (wr_ctrl) begin
            ctrl_r[`TRCT_CTRL_TFH] <= pwdata[`TRCT_CTRL_TFH]; // [RL9]
         end else if (wr_clr && pwdata[`TRCT_ST_HIGH]) begin
            ctrl_r[`TRCT_CTRL_TFH] <= 1'b0; // [RL9]
         end
         if (lo_wrap) begin
            ctrl_r[`TRCT_CTRL_TFL] <= 1'b1; // [RL7] [RL19]
         end else if (wr_ctrl) begin
            ctrl_r[`TRCT_CTRL_TFL] <= pwdata[`TRCT_CTRL_TFL]; // [RL9]
         end else if (wr_clr && pwdata[`TRCT_ST_LOW]) begin
            ctrl_r[`TRCT_CTRL_TFL] <= 1'b0; // [RL9]
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clkctrl_r <= `TRCT_RST_BYTE;
      end else if (wr_clk) begin
         clkctrl_r <= pwdata[7:0] & 8'h30;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cap_flag_r <= 1'b0;
      end else if (cap_evt) begin
         cap_flag_r <= 1'b1; // [RL19]
      end else if (wr_clr && pwdata[`TRCT_ST_CAP]) begin
         cap_flag_r <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_en_r <= `TRCT_RST_ST;
      end else if (wr_en) begin
         irq_en_r <= pwdata[2:0];
      end
   end

   // Low flag only reaches the line while the low-byte enable is set
   assign irq = |(status & irq_en_r & {1'b1, ctrl_r[`TRCT_CTRL_LIEN], 1'b1}); // [RL2] [RL3] [RL8] [RL14]

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_WRAP16_RELOAD: assert property ( // [RL1]
      !split_mode_en && !capture_en && hi_wrap && !wr_cnt_lo && !wr_cnt_hi
      |=> {count_hi_r, count_lo_r} == $past({reload_hi_r, reload_lo_r})
          && ctrl_r[`TRCT_CTRL_TFH])
      else $error("16-bit wrap did not reload and flag");

   AST_CAP16_FREE: assert property ( // [RL11]
      capture_en && !split_mode_en && hi_wrap && !wr_cnt_lo && !wr_cnt_hi
      |=> {count_hi_r, count_lo_r} == 16'h0000)
      else $error("capture mode reloaded on wrap");

   AST_LOW_FLAG: assert property ( // [RL7]
      lo_wrap |=> ctrl_r[`TRCT_CTRL_TFL])
      else $error("low wrap did not set low flag");

   AST_SPLIT_LOW_FREE: assert property ( // [RL5]
      split_mode_en && !run_ctrl && lo_tick && count_lo_r != 8'hff && !wr_cnt_lo
      |=> count_lo_r == $past(count_lo_r) + 8'h01)
      else $error("split low byte did not run freely");

   AST_RUN_HOLD: assert property ( // [RL15]
      !split_mode_en && !run_ctrl && !wr_cnt_lo && !wr_cnt_hi
      |=> $stable(count_lo_r) && $stable(count_hi_r))
      else $error("count moved with run bit clear");

   AST_CAPTURE_LATCH: assert property ( // [RL11]
      cap_evt |=> {reload_hi_r, reload_lo_r} == $past({count_hi_r, count_lo_r})
                  && cap_flag_r)
      else $error("capture did not latch the count");

   AST_FLAG_STICKY: assert property ( // [RL9]
      ctrl_r[`TRCT_CTRL_TFH] && !wr_ctrl && !wr_clr |=> ctrl_r[`TRCT_CTRL_TFH])
      else $error("high flag cleared by hardware");

   AST_SET_WINS: assert property ( // [RL19]
      hi_wrap && wr_ctrl |=> ctrl_r[`TRCT_CTRL_TFH])
      else $error("software write lost a high overflow");

   AST_HIGH_IRQ: assert property ( // [RL14]
      ctrl_r[`TRCT_CTRL_TFH] && irq_en_r[`TRCT_ST_HIGH] |-> irq)
      else $error("high flag enabled but no interrupt");

   AST_LOW_IRQ_GATE: assert property ( // [RL3]
      status == 3'b010 && irq_en_r == 3'b010
      |-> irq == ctrl_r[`TRCT_CTRL_LIEN])
      else $error("low interrupt not gated by its enable");

   AST_SYSTEM_CLOCK_SEL: assert property ( // [RL6]
      clkctrl_r[`TRCT_CLK_LSEL] && run_ctrl && !split_mode_en && !wr_cnt_lo
      && !capture_en && count_lo_r != 8'hff
      |=> count_lo_r == $past(count_lo_r) + 8'h01)
      else $error("system clock select did not count every cycle");

   AST_SPLIT_RELOAD: assert property ( // [RL4]
      split_mode_en && !capture_en && lo_wrap && !wr_cnt_lo
      |=> count_lo_r == $past(reload_lo_r))
      else $error("split low byte did not reload");

   AST_SPLIT_HIGH_HOLD: assert property ( // [RL5]
      split_mode_en && !run_ctrl && !wr_cnt_hi |=> $stable(count_hi_r))
      else $error("split high byte moved with run bit clear");

   AST_SPLIT_CAP_FREE: assert property ( // [RL12]
      split_mode_en && capture_en && lo_wrap && !wr_cnt_lo |=> count_lo_r == 8'h00)
      else $error("split capture low byte reloaded on wrap");

   AST_WRAP16_IRQ: assert property ( // [RL2]
      !split_mode_en && hi_wrap && irq_en_r[`TRCT_ST_HIGH] && !wr_en |=> irq)
      else $error("16-bit overflow raised no interrupt");

   AST_SPLIT_LOW_IRQ: assert property ( // [RL8]
      split_mode_en && ctrl_r[`TRCT_CTRL_TFL] && ctrl_r[`TRCT_CTRL_LIEN]
      && irq_en_r[`TRCT_ST_LOW] |-> irq)
      else $error("split low overflow raised no interrupt");

endmodule : trct_timer

// ===== pkg/trct_cfg.svh
// Constants of the reload/capture timer: register indices, field positions,
// reset values and clock divider counts.
// Assumes inclusion by the package, the design files and the bench.
`ifndef TRCT_CFG_SVH
`define TRCT_CFG_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define TRCT_IDX_CTRL      10'h0c8
`define TRCT_IDX_RELOAD_LO 10'h0ca
`define TRCT_IDX_RELOAD_HI 10'h0cb
`define TRCT_IDX_COUNT_LO  10'h0cc
`define TRCT_IDX_COUNT_HI  10'h0cd
`define TRCT_IDX_CLKCTRL   10'h08e
`define TRCT_IDX_STATUS    10'h0d0
`define TRCT_IDX_IRQ_EN    10'h0d1
`define TRCT_IDX_IRQ_CLR   10'h0d2

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define TRCT_CTRL_TFH   7
`define TRCT_CTRL_TFL   6
`define TRCT_CTRL_LIEN  5
`define TRCT_CTRL_CE    4
`define TRCT_CTRL_SPLIT 3
`define TRCT_CTRL_RUN   2
`define TRCT_CTRL_CSS   1
`define TRCT_CTRL_XCLK  0

// ----------------------------------------------------------------------
// Clock control fields and status / enable / clear layout
// ----------------------------------------------------------------------
`define TRCT_CLK_HSEL   5
`define TRCT_CLK_LSEL   4
`define TRCT_ST_HIGH    0
`define TRCT_ST_LOW     1
`define TRCT_ST_CAP     2

// ----------------------------------------------------------------------
// Reset values and divider counts
// ----------------------------------------------------------------------
`define TRCT_RST_BYTE   8'h00
`define TRCT_RST_ST     3'h0
`define TRCT_DIV_SYS    12
`define TRCT_DIV_EXT    8

`endif

// ===== pkg/trct_pkg.sv
// Types and shared helper functions of the reload/capture timer.
// Assumes trct_cfg.svh is on the include path.
`include "trct_cfg.svh"

package trct_pkg;

   typedef logic [7:0] trct_byte_t;
   typedef logic [2:0] trct_stat_t;

   // Word address match of a register index on the APB address
   function automatic logic trct_hit(input logic [11:0] addr, input logic [9:0] idx);
      return addr == {idx, 2'b00};
   endfunction : trct_hit

   // Per-byte count clock: full rate, or the divided source picked by xclk
   function automatic logic trct_tick_sel(input logic sys_sel, input logic xclk,
                                          input logic div_sys, input logic div_ext);
      return sys_sel | (xclk ? div_ext : div_sys);
   endfunction : trct_tick_sel

endpackage : trct_pkg
